// [common/mirror_test_pkg.sv]
package mirror_test_pkg;

    // ****************************************
    // register map (word offsets as byte addresses)
    // ****************************************
    localparam logic [7:0] CTRL_OFF      = 8'h00;
    localparam logic [7:0] FWD_COORD_OFF = 8'h04;
    localparam logic [7:0] REV_COORD_OFF = 8'h08;
    localparam logic [7:0] DWELL_OFF     = 8'h0C;
    localparam logic [7:0] STATUS_OFF    = 8'h10;
    localparam logic [7:0] MASK_OFF      = 8'h14;
    localparam logic [7:0] SPEED_OFF     = 8'h18;
    localparam logic [7:0] COUNT_OFF     = 8'h1C;
    localparam logic [7:0] STATE_OFF     = 8'h20;

    // ****************************************
    // fields
    // ****************************************
    localparam int CTRL_REV_EN_BIT = 0;
    localparam int EV_WIDTH        = 9;
    localparam int EV_NO_STILL     = 0;
    localparam int EV_COUNT_FAULT  = 1;
    localparam int EV_VEL_FAULT    = 2;
    localparam int EV_NOT_ZERO     = 3;
    localparam int EV_JUMP         = 4;
    localparam int EV_WRONG_DIR    = 5;
    localparam int EV_SPEED        = 6;
    localparam int EV_DRIFT        = 7;
    localparam int EV_PASS_DONE    = 8;

    localparam logic [31:0] DWELL_RESET = 32'h0000_C350;
    localparam logic [15:0] FWD_RESET   = 16'h0400;
    localparam logic [15:0] REV_RESET   = 16'h0000;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ          = 50_000_000;
    localparam int STILL_WAIT_MS   = 10;
    localparam int STILL_WAIT_CYC  = CLK_HZ / 1000 * STILL_WAIT_MS;
    localparam int DRIFT_LIMIT     = 3;
    localparam int MAX_STEP        = 1;
    localparam int SPEED_TOL_PCT   = 1;

    typedef struct packed {
        logic stop;
        logic zero;
        logic scan_fwd;
        logic accel_rev;
    } mirror_cmd_t;

    typedef struct packed {
        logic near_still;
        logic count_fault;
        logic vel_fault;
        logic in_scan_gate;
        logic at_speed;
        logic enc_fwd;
        logic enc_rev;
    } mirror_stat_t;

endpackage

// [design/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;

    // two stages; the first is read only by the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// [design/mirror_drive_test_sequencer.sv]
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module mirror_drive_test_sequencer #(
    parameter int          STILL_WAIT  = mirror_test_pkg::STILL_WAIT_CYC,
    parameter int          CWIDTH      = 16,
    parameter logic [31:0] NOMINAL_CYC = 32'h0000_0000
) (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          cyc_i,
    input  wire logic                          stb_i,
    input  wire logic                          we_i,
    input  wire logic [7:0]                    adr_i,
    input  wire logic [3:0]                    sel_i,
    input  wire logic [31:0]                   dat_i,
    output logic      [31:0]                   dat_o,
    output logic                               ack_o,
    output logic                               irq_o,
    input  wire logic                          start_btn_i,
    input  wire mirror_test_pkg::mirror_stat_t stat_i,
    output mirror_test_pkg::mirror_cmd_t       cmd_o
);
    import mirror_test_pkg::*;

    // coordinate width is bounded by the 16-bit reset constants
    if (CWIDTH < 4 || CWIDTH > 16 || STILL_WAIT < 1) begin : g_bad_params
        $error("parameter out of range");
    end

    typedef enum {
        S_IDLE, S_STOP1, S_ZERO, S_CHK_ZERO, S_SCAN, S_TIME, S_FSTOP, S_FDWELL,
        S_FCHK, S_ACCEL, S_COAST, S_RSTOP, S_RDWELL, S_RCHK
    } state_t;

    // ****************************************
    // synchronised pins
    // ****************************************
    mirror_stat_t st;
    logic         start_s;
    pin_sync #(.WIDTH(8)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({start_btn_i, stat_i}),
        .q_o   ({start_s, st})
    );

    state_t            state_reg;
    logic [31:0]       timer_reg;
    logic [31:0]       dwell_reg, dwell_len_reg;
    logic [CWIDTH-1:0] pos_reg, fwd_reg, rev_reg, mid_reg, drift_reg;
    logic              rev_en_reg;
    logic [31:0]       speed_reg;
    logic [EV_WIDTH-1:0] status_reg, mask_reg, ev;
    logic              fwd_d, rev_d, start_d;

    wire fwd_p   = st.enc_fwd & ~fwd_d;
    wire rev_p   = st.enc_rev & ~rev_d;
    wire start_p = start_s & ~start_d;
    // a rising edge on one encoder line without one on the other counts one step;
    // a pulse on both lines at once means the encoder skipped
    wire jump    = fwd_p & rev_p;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fwd_d   <= 1'b0;
            rev_d   <= 1'b0;
            start_d <= 1'b0;
        end else begin
            fwd_d   <= st.enc_fwd;
            rev_d   <= st.enc_rev;
            start_d <= start_s;
        end
    end

    // encoder position, cleared while zeroing
    always_ff @(posedge clk_i) begin
        if (rst_i || state_reg == S_ZERO) begin
            pos_reg <= '0;
        end else if (fwd_p && !rev_p) begin
            pos_reg <= pos_reg + 1'b1;
        end else if (rev_p && !fwd_p) begin
            pos_reg <= pos_reg - 1'b1;
        end
    end

    // ****************************************
    // test sequence
    // ****************************************
    logic [32:0] diff;
    logic [39:0] tol;
    always_comb begin
        diff = (speed_reg > NOMINAL_CYC) ? {1'b0, speed_reg - NOMINAL_CYC}
                                         : {1'b0, NOMINAL_CYC - speed_reg};
        tol  = 40'(NOMINAL_CYC) * 40'(SPEED_TOL_PCT);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= S_IDLE;
            timer_reg <= '0;
            dwell_reg <= '0;
            drift_reg <= '0;
            mid_reg   <= '0;
            speed_reg <= '0;
            cmd_o     <= '0;
            ev        <= '0;
        end else begin
            ev <= '0;
            unique case (state_reg)
                S_IDLE: begin
                    cmd_o <= '0;
                    if (start_p) begin
                        cmd_o     <= '{stop: 1'b1, default: 1'b0};
                        dwell_reg <= dwell_len_reg;
                        timer_reg <= '0;
                        state_reg <= S_STOP1;
                    end
                end
                S_STOP1: begin
                    timer_reg <= timer_reg + 1;
                    if (st.near_still) begin
                        ev[EV_COUNT_FAULT] <= st.count_fault;
                        ev[EV_VEL_FAULT]   <= st.vel_fault;
                        cmd_o     <= '{zero: 1'b1, default: 1'b0};
                        state_reg <= S_ZERO;
                    end else if (timer_reg >= 32'(STILL_WAIT - 1)) begin
                        ev[EV_NO_STILL] <= 1'b1;
                        cmd_o     <= '0;
                        state_reg <= S_IDLE;
                    end
                end
                S_ZERO: if (!st.in_scan_gate) begin
                    cmd_o     <= '{stop: 1'b1, default: 1'b0};
                    state_reg <= S_CHK_ZERO;
                end
                S_CHK_ZERO: begin
                    // mirror held by stop; count must read zero here
                    ev[EV_NOT_ZERO] <= (pos_reg != '0);
                    cmd_o     <= '{scan_fwd: 1'b1, default: 1'b0};
                    state_reg <= S_SCAN;
                end
                S_SCAN, S_TIME: begin
                    if (state_reg == S_TIME) speed_reg <= speed_reg + 1;
                    if (jump || rev_p) begin
                        ev[EV_JUMP]      <= jump;
                        ev[EV_WRONG_DIR] <= rev_p & ~jump;
                        cmd_o     <= '{zero: 1'b1, default: 1'b0};
                        state_reg <= S_ZERO;
                    end else if (state_reg == S_SCAN && st.at_speed) begin
                        speed_reg <= '0;
                        state_reg <= S_TIME;
                    end else if (state_reg == S_TIME && pos_reg >= fwd_reg) begin
                        cmd_o     <= '{stop: 1'b1, default: 1'b0};
                        drift_reg <= '0;
                        state_reg <= S_FSTOP;
                    end
                end
                S_FSTOP, S_RSTOP: begin
                    if (fwd_p || rev_p) drift_reg <= drift_reg + 1'b1;
                    if (st.near_still) begin
                        timer_reg <= dwell_reg;
                        state_reg <= (state_reg == S_FSTOP) ? S_FDWELL : S_RDWELL;
                    end
                end
                S_FDWELL, S_RDWELL: begin
                    if (fwd_p || rev_p) drift_reg <= drift_reg + 1'b1;
                    if (timer_reg == '0) begin
                        state_reg <= (state_reg == S_FDWELL) ? S_FCHK : S_RCHK;
                    end else begin
                        timer_reg <= timer_reg - 1;
                    end
                end
                S_FCHK: begin
                    // speed reported as elapsed cycles of the timed span
                    ev[EV_SPEED] <= ({diff, 7'h00} > tol * 40'd128 / 40'd100);
                    ev[EV_DRIFT] <= (drift_reg > CWIDTH'(DRIFT_LIMIT));
                    if (st.in_scan_gate) begin
                        cmd_o     <= '{zero: 1'b1, default: 1'b0};
                        state_reg <= S_ZERO;
                    end else if (rev_en_reg) begin
                        mid_reg   <= CWIDTH'(({1'b0, fwd_reg} + {1'b0, rev_reg}) >> 1);
                        cmd_o     <= '{accel_rev: 1'b1, default: 1'b0};
                        state_reg <= S_ACCEL;
                    end else begin
                        ev[EV_PASS_DONE] <= 1'b1;
                        cmd_o     <= '0;
                        state_reg <= S_IDLE;
                    end
                end
                S_ACCEL, S_COAST: begin
                    if (jump || fwd_p) begin
                        ev[EV_WRONG_DIR] <= fwd_p & ~jump;
                        ev[EV_JUMP]      <= jump;
                        cmd_o     <= '{stop: 1'b1, default: 1'b0};
                        state_reg <= S_IDLE;
                    end else if (state_reg == S_ACCEL && pos_reg <= mid_reg) begin
                        cmd_o     <= '0;
                        state_reg <= S_COAST;
                    end else if (state_reg == S_COAST && pos_reg <= rev_reg) begin
                        cmd_o     <= '{stop: 1'b1, default: 1'b0};
                        drift_reg <= '0;
                        state_reg <= S_RSTOP;
                    end
                end
                S_RCHK: begin
                    ev[EV_DRIFT] <= (drift_reg > CWIDTH'(DRIFT_LIMIT));
                    ev[EV_PASS_DONE] <= 1'b1;
                    cmd_o     <= '{scan_fwd: 1'b1, default: 1'b0};
                    state_reg <= S_SCAN;
                end
            endcase
        end
    end

    // ****************************************
    // wishbone slave
    // ****************************************
    wire req = cyc_i & stb_i & ~ack_o;
    wire wr  = req & we_i & sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fwd_reg       <= FWD_RESET[CWIDTH-1:0];
            rev_reg       <= REV_RESET[CWIDTH-1:0];
            rev_en_reg    <= 1'b0;
            dwell_len_reg <= DWELL_RESET;
            mask_reg      <= '0;
        end else if (wr) begin
            unique case (adr_i)
                CTRL_OFF:      rev_en_reg    <= dat_i[CTRL_REV_EN_BIT];
                FWD_COORD_OFF: fwd_reg       <= dat_i[CWIDTH-1:0];
                REV_COORD_OFF: rev_reg       <= dat_i[CWIDTH-1:0];
                DWELL_OFF:     dwell_len_reg <= dat_i;
                MASK_OFF:      mask_reg      <= dat_i[EV_WIDTH-1:0];
                default: ;
            endcase
        end
    end

    // read of status clears it; new events win over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= '0;
        end else if (req && !we_i && adr_i == STATUS_OFF) begin
            status_reg <= ev;
        end else begin
            status_reg <= status_reg | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= '0;
        end else begin
            ack_o <= req;
            dat_o <= '0;
            if (req && !we_i) begin
                unique case (adr_i)
                    CTRL_OFF:      dat_o <= 32'(rev_en_reg);
                    FWD_COORD_OFF: dat_o <= 32'(fwd_reg);
                    REV_COORD_OFF: dat_o <= 32'(rev_reg);
                    DWELL_OFF:     dat_o <= dwell_len_reg;
                    STATUS_OFF:    dat_o <= 32'(status_reg);
                    MASK_OFF:      dat_o <= 32'(mask_reg);
                    SPEED_OFF:     dat_o <= speed_reg;
                    COUNT_OFF:     dat_o <= 32'(pos_reg);
                    STATE_OFF:     dat_o <= 32'(state_reg);
                    default:       dat_o <= '0;
                endcase
            end
        end
    end

    assign irq_o = |(status_reg & mask_reg);
endmodule
`default_nettype wire

// [testbench/mirror_test_props.sv]
`timescale 1ns/1ps
`default_nettype none
module mirror_test_props (
    input wire logic                         clk_i,
    input wire logic                         rst_i,
    input wire logic                         cyc_i,
    input wire logic                         stb_i,
    input wire logic                         we_i,
    input wire logic [7:0]                   adr_i,
    input wire logic [31:0]                  dat_o,
    input wire logic                         ack_o,
    input wire logic                         irq_o,
    input wire mirror_test_pkg::mirror_cmd_t cmd_o
);
    import mirror_test_pkg::*;
    // ****************
    // port checks
    // ****************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
    ack_late_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
    dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("data outside ack");
    unmap_rd_a: assert property (ack_o && $past(!we_i && adr_i > STATE_OFF) |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    reset_quiet_a: assert property ($past(rst_i) |-> cmd_o == '0 && !ack_o && !irq_o)
        else $error("outputs busy after reset");
    one_cmd_a: assert property ($onehot0(cmd_o)) else $error("two commands");
    zero_stop_a: assert property ($fell(cmd_o.zero) && !$past(rst_i) |-> cmd_o.stop)
        else $error("zero not followed by stop");
    first_cmd_a: assert property ($past(cmd_o) == '0 && cmd_o != '0 |-> cmd_o.stop || cmd_o.scan_fwd)
        else $error("bad first command");
    rev_coast_a: assert property ($fell(cmd_o.accel_rev) && !$past(rst_i) |-> cmd_o == '0)
        else $error("no coast after reverse");
endmodule
`default_nettype wire

// [testbench/mirror_drive_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mirror_drive_model (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire mirror_test_pkg::mirror_cmd_t cmd_i,
    input  wire logic                         slow_i,
    input  wire logic                         rev_pulse_i,
    input  wire logic                         rezero_i,
    input  wire logic [1:0]                   fault_i,
    input  wire logic [3:0]                   drift_i,
    output mirror_test_pkg::mirror_stat_t     stat_o
);
    import mirror_test_pkg::*;
    int         dir;
    int         extra;
    int         zt;
    int         sc;
    logic [1:0] ph;
    // ****************
    // mirror motion
    // ****************
    // pulses are two cycles wide so the two-stage sync never drops one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir <= 0;
            extra <= 0;
            zt <= 0;
            sc <= 0;
            ph <= 2'h0;
            stat_o <= '{in_scan_gate: 1'b1, default: 1'b0};
        end else begin
            ph <= ph + 2'h1;
            if (cmd_i.scan_fwd) dir <= 1;
            else if (cmd_i.accel_rev) dir <= -1;
            else if (cmd_i != '0) dir <= 0;
            if (cmd_i.scan_fwd) extra <= drift_i;
            else if (cmd_i.stop && ph == 2'h3 && extra > 0) extra <= extra - 1;
            zt <= cmd_i.zero ? zt + 1 : 0;
            if (cmd_i.zero) stat_o.in_scan_gate <= (zt < 6);
            else if (cmd_i.stop && rezero_i) stat_o.in_scan_gate <= 1'b1;
            sc <= (cmd_i.stop && extra == 0) ? sc + 1 : 0;
            stat_o.near_still <= (sc > 3) && !slow_i;
            stat_o.count_fault <= fault_i[1];
            stat_o.vel_fault <= fault_i[0];
            stat_o.at_speed <= (dir == 1);
            stat_o.enc_fwd <= ((dir == 1) || (cmd_i.stop && extra > 0)) && !ph[1];
            stat_o.enc_rev <= ((dir == -1) && !ph[1]) || (rev_pulse_i && dir == 1 && ph[1]);
        end
    end
endmodule
`default_nettype wire

// [testbench/mirror_drive_test_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module mirror_drive_test_sequencer_tb;
    import mirror_test_pkg::*;
    localparam logic [31:0] NOM = 32'h0000_0040;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, start_btn_i;
    logic slow, rev_pulse, rezero, zero_d;
    logic [1:0] fault;
    logic [3:0] drift;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rdat;
    logic [8:0] acc;
    mirror_stat_t stat;
    mirror_cmd_t cmd;
    int failures, compares, k, i, spd, zeros, z0;
    mirror_drive_test_sequencer #(.STILL_WAIT(50), .NOMINAL_CYC(NOM)) dut (.clk_i(clk_i),
        .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .start_btn_i(start_btn_i),
        .stat_i(stat), .cmd_o(cmd));
    mirror_drive_model far (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .slow_i(slow),
        .rev_pulse_i(rev_pulse), .rezero_i(rezero), .fault_i(fault), .drift_i(drift),
        .stat_o(stat));
    // counts zero commands so a repeated zeroing can be seen
    always @(posedge clk_i) begin
        zero_d <= cmd.zero;
        if (cmd.zero === 1'b1 && zero_d !== 1'b1) zeros <= zeros + 1;
    end
    // ****************
    // bus and run tasks
    // ****************
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rdat = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0;
    endtask
    // events are gathered over several status reads since each read clears them
    task automatic run();
        int n, m;
        acc = '0;
        start_btn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        start_btn_i <= 1'b0;
        for (n = 0; n < 20; n++) begin
            for (m = 0; m < 2000 && irq_o !== 1'b1; m++) @(posedge clk_i);
            if (irq_o !== 1'b1) begin
                failures++;
                break;
            end
            wb(1'b0, STATUS_OFF, 32'h0);
            acc |= rdat[8:0];
            if (acc[EV_WRONG_DIR]) rev_pulse <= 1'b0;
            if (acc[EV_SPEED]) rezero <= 1'b0;
            if (acc[EV_PASS_DONE] || acc[EV_NO_STILL]) break;
        end
        for (m = 0; m < 2000 && cmd !== '0; m++) @(posedge clk_i);
        if (cmd !== '0) failures++;
    endtask
    task automatic results();
        if (failures == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        repeat (90000) @(posedge clk_i);
        failures++;
        results();
    end
    // ****************
    // scenarios
    // ****************
    initial begin
        {rst_i, cyc_i, stb_i, we_i, start_btn_i, slow, rev_pulse, rezero} = 8'h80;
        {adr_i, sel_i, dat_i, fault, drift} = '0;
        sel_i = 4'hF;
        failures = 0;
        compares = 0;
        void'($urandom(77));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, DWELL_OFF, 32'h0);
        `CHK(rdat, DWELL_RESET)
        wb(1'b0, FWD_COORD_OFF, 32'h0);
        `CHK(rdat, {16'h0, FWD_RESET})
        wb(1'b0, 8'h24, 32'h0);
        `CHK(rdat, 32'h0)
        wb(1'b1, DWELL_OFF, 32'h14);
        wb(1'b1, FWD_COORD_OFF, 32'h8);
        wb(1'b1, MASK_OFF, 32'h1FF);
        repeat (20) @(posedge clk_i);
        `CHK(cmd, 4'h0)
        for (k = 0; k < 6; k++) begin
            slow <= (k == 0);
            drift <= (k == 2) ? 4'h5 : 4'h0;
            rev_pulse <= (k == 3);
            rezero <= (k == 5);
            fault <= (k == 4) ? 2'(1 + $urandom % 3) : 2'h0;
            z0 = zeros;
            run();
            wb(1'b0, SPEED_OFF, 32'h0);
            spd = int'(rdat) - int'(NOM);
            `CHK(acc[EV_NO_STILL], k == 0)
            `CHK(acc[2:1], (k == 4) ? {fault[0], fault[1]} : 2'h0)
            `CHK(acc[EV_NOT_ZERO], 1'b0)
            `CHK(acc[EV_WRONG_DIR], k == 3)
            `CHK(acc[EV_DRIFT], k == 2)
            `CHK(acc[EV_JUMP], 1'b0)
            if (k == 5) `CHK(zeros - z0, 2)
            if (k == 1) `CHK(acc[EV_SPEED], (spd < 0 ? -spd : spd) * 100 > int'(NOM))
            if (k == 1 || k == 3 || k == 5) `CHK(acc[EV_PASS_DONE], 1'b1)
            `CHK(irq_o, 1'b0)
        end
        fault <= 2'h0;
        wb(1'b1, REV_COORD_OFF, 32'h2);
        wb(1'b1, CTRL_OFF, 32'h1);
        start_btn_i <= 1'b1;
        for (i = 0; i < 4000 && cmd.accel_rev !== 1'b1; i++) @(posedge clk_i);
        start_btn_i <= 1'b0;
        `CHK(cmd.accel_rev, 1'b1)
        for (i = 0; i < 4000 && cmd.stop !== 1'b1; i++) @(posedge clk_i);
        `CHK(cmd.stop, 1'b1)
        wb(1'b1, CTRL_OFF, 32'h0);
        run();
        `CHK(acc[EV_WRONG_DIR], 1'b0)
        `CHK(acc[EV_DRIFT], 1'b0)
        results();
    end
endmodule
bind mirror_drive_test_sequencer mirror_test_props props (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .irq_o(irq_o), .cmd_o(cmd_o));
`default_nettype wire
